// ---- design/qdac_pkg.sv ----
// package: link constants, frame layout and timing counts for the quad converter link
package qdac_pkg;

  localparam int NUM_CH     = 4;
  localparam int CODE_W     = 16;
  localparam int FRAME_BITS = 32;

  // frame layout: command, address, data code, four spare low bits
  localparam int CMD_HI  = 27;
  localparam int CMD_LO  = 24;
  localparam int ADDR_HI = 23;
  localparam int ADDR_LO = 20;
  localparam int DATA_HI = 19;
  localparam int DATA_LO = 4;

  localparam logic [3:0] CMD_WR_IN       = 4'h0;
  localparam logic [3:0] CMD_UPDATE      = 4'h1;
  localparam logic [3:0] CMD_WR_UPDATE   = 4'h2;
  localparam logic [3:0] CMD_WR_UPD_ALL  = 4'h3;
  localparam logic [3:0] CMD_SET_CLRCODE = 4'h5;
  localparam logic [3:0] ADDR_ALL        = 4'hF;

  // clear code selects and the codes they produce
  localparam logic [1:0]  CLRSEL_ZERO  = 2'h0;
  localparam logic [1:0]  CLRSEL_MID   = 2'h1;
  localparam logic [1:0]  CLRSEL_FULL  = 2'h2;
  localparam logic [1:0]  CLRSEL_RESET = CLRSEL_ZERO;
  localparam logic [15:0] CODE_ZERO    = 16'h0000;
  localparam logic [15:0] CODE_MID     = 16'h8000;
  localparam logic [15:0] CODE_FULL    = 16'hFFFF;

  // timing in ns, counts at the system clock
  localparam int CLK_PERIOD_NS    = 8;
  localparam int T_SCLK_MIN_NS    = 20;
  localparam int T_GAP_ONE_NS     = 1900;
  localparam int T_GAP_ALL_NS     = 10500;
  localparam int T_CLR_SETTLE_NS  = 10600;
  localparam int T_STROBE_LOW_NS  = 20;
  localparam int T_CLR_LOW_NS     = 10;
  localparam int SCLK_HALF_CYC    = 4;
  localparam int GAP_ONE_CYC      = (T_GAP_ONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_ALL_CYC      = (T_GAP_ALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLR_SETTLE_CYC   = (T_CLR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_LOW_CYC   = (T_STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLR_LOW_CYC      = (T_CLR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_MIN_HALF    = (T_SCLK_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // true when a frame updates every channel, which needs the long gap
  function automatic logic qdac_is_all_update(input logic [31:0] frame);
    logic [3:0] cmd;
    logic [3:0] adr;
    cmd = frame[CMD_HI:CMD_LO];
    adr = frame[ADDR_HI:ADDR_LO];
    return (cmd == CMD_WR_UPD_ALL) ||
           ((cmd == CMD_UPDATE || cmd == CMD_WR_UPDATE) && adr == ADDR_ALL);
  endfunction : qdac_is_all_update

endpackage : qdac_pkg

// ---- design/qdac_link_if.sv ----
// interface: serial link wires between host and converter
`timescale 1ns/1ps
`default_nettype none
interface qdac_link_if;
  logic sclk;
  logic sync_n;
  logic din;
  logic load_strobe_n;
  logic clear_n;

  modport host (output sclk, output sync_n, output din, output load_strobe_n, output clear_n);
  modport dev  (input sclk, input sync_n, input din, input load_strobe_n, input clear_n);
endinterface : qdac_link_if
`default_nettype wire

// ---- design/qdac_sync.sv ----
// module: two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module qdac_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] meta;

  // no reset: reset is held long enough to flush both stages
  always_ff @(posedge clk_sys) begin
    meta <= din;
    dout <= meta;
  end

endmodule : qdac_sync
`default_nettype wire

// ---- design/qdac_dev.sv ----
// module: converter end, frame receiver with input, converter and clear-code registers
`timescale 1ns/1ps
`default_nettype none
module qdac_dev
  import qdac_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  qdac_link_if.dev                    link,
  input  wire logic                   por_mid,
  output var  logic [3:0][15:0]       dac_code,
  output var  logic [3:0][15:0]       input_code,
  output var  logic [1:0]             clear_sel,
  output var  logic                   frame_done,
  output var  logic                   frame_abort
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int NPIN = 6;

  logic [NPIN-1:0] pins_raw;
  logic [NPIN-1:0] pins;
  logic            sclk_s;
  logic            sync_s;
  logic            din_s;
  logic            strobe_s;
  logic            clr_s;
  logic            strap_s;

  assign pins_raw = {por_mid, link.clear_n, link.load_strobe_n, link.din, link.sync_n,
                     link.sclk};

  qdac_sync #(.W(NPIN)) u_sync (
    .clk_sys (clk_sys),
    .din     (pins_raw),
    .dout    (pins)
  );

  assign sclk_s  = pins[0];
  assign sync_s  = pins[1];
  assign din_s   = pins[2];
  assign strobe_s = pins[3];
  assign clr_s   = pins[4];
  assign strap_s = pins[5];

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic             sclk_q;
    logic             sync_q;
    logic             clr_q;
    logic             armed;
    logic [5:0]       cnt;
    logic [31:0]      shreg;
    logic [3:0][15:0] in_reg;
    logic [3:0][15:0] dac_reg;
    logic [3:0]       pend;
    logic [1:0]       clr_sel;
    logic             strap_done;
    logic             done;
    logic             abort;
  } qdac_dev_s;

  qdac_dev_s s;
  qdac_dev_s next_s;

  // code produced by a clear-code select
  function automatic logic [15:0] clr_code(input logic [1:0] sel);
    case (sel)
      CLRSEL_MID:  return CODE_MID;
      CLRSEL_FULL: return CODE_FULL;
      default:     return CODE_ZERO;
    endcase
  endfunction : clr_code

  // channel mask for an address; the all-channel address hits every one
  function automatic logic [3:0] ch_mask(input logic [3:0] adr);
    logic [3:0] m;
    m = 4'h0;
    if (adr == ADDR_ALL) begin
      m = 4'hF;
    end else if (adr < 4'(NUM_CH)) begin
      m[adr[1:0]] = 1'b1;
    end
    return m;
  endfunction : ch_mask

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic        sync_fall;
  logic        sync_rise;
  logic        sclk_fall;
  logic        clr_fall;
  logic [31:0] frame;
  logic        frame_end;
  logic [3:0]  cmd;
  logic [3:0]  wmask;
  logic [3:0]  umask;
  logic [15:0] code;

  always_comb begin
    next_s    = s;
    next_s.done  = 1'b0;
    next_s.abort = 1'b0;
    next_s.sclk_q = sclk_s;
    next_s.sync_q = sync_s;
    next_s.clr_q  = clr_s;

    sync_fall = s.sync_q && !sync_s;
    sync_rise = !s.sync_q && sync_s;
    sclk_fall = s.sclk_q && !sclk_s;
    clr_fall  = s.clr_q && !clr_s;
    frame     = s.shreg;
    frame_end = 1'b0;

    // a new frame arms the shift register and restarts the bit count
    if (sync_fall) begin
      next_s.armed = 1'b1;
      next_s.cnt   = 6'h00;
    end else if (s.armed && sync_rise) begin
      // sync left early: drop the partial frame without acting on it
      next_s.armed = 1'b0;
      next_s.abort = 1'b1;
    end else if (s.armed && !sync_s && sclk_fall) begin
      // first bit lands in the msb after 32 shifts
      frame          = {s.shreg[30:0], din_s};
      next_s.shreg   = frame;
      next_s.cnt     = s.cnt + 6'h01;
      if (s.cnt == 6'(FRAME_BITS - 1)) begin
        frame_end    = 1'b1;
        next_s.armed = 1'b0; // later falls are ignored until sync falls again
      end
    end

    // load strobe is level sensitive so a strobe tied low acts on every write made while clear is high
    if (!strobe_s && clr_s) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (s.pend[i]) begin
          next_s.dac_reg[i] = s.in_reg[i];
        end
      end
      next_s.pend = 4'h0;
    end

    // decode a completed frame; a pending flag set here beats the strobe clear
    cmd   = frame[CMD_HI:CMD_LO];
    code  = frame[DATA_HI:DATA_LO];
    wmask = 4'h0;
    umask = 4'h0;
    if (frame_end) begin
      next_s.done = 1'b1;
      case (cmd)
        CMD_WR_IN:       wmask = ch_mask(frame[ADDR_HI:ADDR_LO]);
        CMD_UPDATE:      umask = ch_mask(frame[ADDR_HI:ADDR_LO]);
        CMD_WR_UPDATE: begin
          wmask = ch_mask(frame[ADDR_HI:ADDR_LO]);
          umask = wmask;
        end
        CMD_WR_UPD_ALL: begin
          wmask = ch_mask(frame[ADDR_HI:ADDR_LO]);
          umask = 4'hF;
        end
        CMD_SET_CLRCODE: next_s.clr_sel = code[1:0];
        default:         ;
      endcase
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (wmask[i]) begin
        next_s.in_reg[i] = code;
        next_s.pend[i]   = 1'b1;
      end
      if (umask[i]) begin
        next_s.dac_reg[i] = wmask[i] ? code : next_s.in_reg[i];
        next_s.pend[i]    = 1'b0;
      end
    end

    // clear edge wins over everything else in its cycle except the strap load after reset
    if (clr_fall) begin
      for (int i = 0; i < NUM_CH; i++) begin
        next_s.in_reg[i]  = clr_code(s.clr_sel);
        next_s.dac_reg[i] = clr_code(s.clr_sel);
      end
      next_s.pend = 4'h0;
    end

    // strap is read once, the first cycle after reset release
    if (!s.strap_done) begin
      next_s.strap_done = 1'b1;
      for (int i = 0; i < NUM_CH; i++) begin
        next_s.in_reg[i]  = strap_s ? CODE_MID : CODE_ZERO;
        next_s.dac_reg[i] = strap_s ? CODE_MID : CODE_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s            <= '0;
      s.sclk_q     <= 1'b1;
      s.sync_q     <= 1'b1;
      s.clr_q      <= 1'b1;
      s.clr_sel    <= CLRSEL_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  assign dac_code    = s.dac_reg; // plain binary code per channel
  assign input_code  = s.in_reg;
  assign clear_sel   = s.clr_sel;
  assign frame_done  = s.done;
  assign frame_abort = s.abort;

endmodule : qdac_dev
`default_nettype wire

// ---- design/qdac_host.sv ----
// module: host end, sends 32-bit frames and drives load strobe and clear pulses
`timescale 1ns/1ps
`default_nettype none
module qdac_host
  import qdac_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        send,
  input  wire logic [31:0] frame,
  input  wire logic        load_req,
  input  wire logic        clear_req,
  output var  logic        ready,
  qdac_link_if.host        link
);

  typedef enum {ST_IDLE, ST_SETUP, ST_SHIFT, ST_GAP, ST_LOAD, ST_CLR, ST_CLR_WAIT} qdac_host_e;

  typedef struct packed {
    qdac_host_e  st;
    logic [10:0] tmr;
    logic [5:0]  bits;
    logic [31:0] sh;
    logic        all_upd;
    logic        sclk;
    logic        sync_n;
    logic        din;
    logic        strobe_n;
    logic        clr_n;
    logic        rdy;
  } qdac_host_s;

  qdac_host_s s;
  qdac_host_s next_s;

  // serial clock half period; 4 cycles gives 32 ns, a 64 ns period, well under the 50 MHz limit
  localparam logic [10:0] HALF = 11'(SCLK_HALF_CYC > SCLK_MIN_HALF ? SCLK_HALF_CYC
                                                                   : SCLK_MIN_HALF);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    next_s     = s;
    next_s.rdy = 1'b0;
    if (s.tmr != 11'h000) begin
      next_s.tmr = s.tmr - 11'h001;
    end
    case (s.st)
      ST_IDLE: begin
        next_s.rdy = 1'b1;
        if (clear_req) begin
          next_s.st    = ST_CLR;
          next_s.clr_n = 1'b0;
          next_s.tmr   = 11'(CLR_LOW_CYC - 1);
          next_s.rdy   = 1'b0;
        end else if (load_req) begin
          next_s.st       = ST_LOAD;
          next_s.strobe_n = 1'b0;
          next_s.tmr      = 11'(STROBE_LOW_CYC - 1);
          next_s.rdy      = 1'b0;
        end else if (send) begin
          // msb goes out first, sync leads the first fall by a half period plus one cycle
          next_s.st      = ST_SETUP;
          next_s.sh      = frame;
          next_s.din     = frame[31];
          next_s.all_upd = qdac_is_all_update(frame);
          next_s.sync_n  = 1'b0;
          next_s.bits    = 6'h00;
          next_s.tmr     = HALF - 11'h001;
          next_s.rdy     = 1'b0;
        end
      end
      ST_SETUP: begin
        if (s.tmr == 11'h000) begin
          next_s.st  = ST_SHIFT;
          next_s.tmr = 11'h000;
        end
      end
      ST_SHIFT: begin
        if (s.tmr == 11'h000) begin
          next_s.tmr = HALF - 11'h001;
          if (s.sclk) begin
            next_s.sclk = 1'b0;
            next_s.bits = s.bits + 6'h01;
          end else if (s.bits == 6'(FRAME_BITS)) begin
            // sync held low through all 32 falls, released after the last
            next_s.sclk   = 1'b1;
            next_s.sync_n = 1'b1;
            next_s.st     = ST_GAP;
            next_s.tmr    = s.all_upd ? 11'(GAP_ALL_CYC - 1) : 11'(GAP_ONE_CYC - 1);
          end else begin
            next_s.sclk = 1'b1;
            next_s.sh   = {s.sh[30:0], 1'b0};
            next_s.din  = s.sh[30];
          end
        end
      end
      ST_LOAD: begin
        if (s.tmr == 11'h000) begin
          next_s.strobe_n = 1'b1;
          next_s.st       = ST_IDLE;
          next_s.rdy      = 1'b1;
        end
      end
      ST_CLR: begin
        if (s.tmr == 11'h000) begin
          next_s.clr_n = 1'b1;
          next_s.st    = ST_CLR_WAIT;
          next_s.tmr   = 11'(CLR_SETTLE_CYC - CLR_LOW_CYC - 1);
        end
      end
      ST_GAP, ST_CLR_WAIT: begin
        if (s.tmr == 11'h000) begin
          next_s.st  = ST_IDLE;
          next_s.rdy = 1'b1;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s        <= '0;
      s.st     <= ST_IDLE;
      s.sclk   <= 1'b1;
      s.sync_n <= 1'b1;
      s.strobe_n <= 1'b1;
      s.clr_n  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // link pins straight from flops
  assign link.sclk          = s.sclk;
  assign link.sync_n        = s.sync_n;
  assign link.din           = s.din;
  assign link.load_strobe_n = s.strobe_n;
  assign link.clear_n       = s.clr_n;
  assign ready              = s.rdy;

endmodule : qdac_host
`default_nettype wire

// ---- bench/qdac_link_assertions.sv ----
// checker: host-side timing of the serial link wires
`timescale 1ns/1ps
`default_nettype none
module qdac_link_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  input wire logic load_strobe_n,
  input wire logic clear_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic       sclk_q;
  logic [5:0] fall_cnt;

  //////////////////////////////////////////////////////////////////////////////
  // count serial clock falls inside a frame; cleared while sync is high
  always_ff @(posedge clk_sys) begin
    sclk_q <= sclk;
    if (rst || sync_n) begin
      fall_cnt <= 6'h00;
    end else if (sclk_q && !sclk) begin
      fall_cnt <= fall_cnt + 6'h01;
    end
  end

  // each phase of the host clock lasts four system cycles
  sequence s_high4;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence s_low4;
    !sclk [*4] ##1 sclk;
  endsequence
  // sync leads the first fall by five cycles, one more than a phase
  sequence s_setup5;
    sclk [*5] ##1 !sclk;
  endsequence
  // strobe stays low three cycles, clear two
  sequence s_strobe3;
    !load_strobe_n [*3] ##1 load_strobe_n;
  endsequence
  sequence s_clear2;
    !clear_n [*2] ##1 clear_n;
  endsequence

  //////////////////////////////////////////////////////////////////////////////
  AST_SYNC_SETUP: assert property ($fell(sync_n) |-> s_setup5)
    else $error("serial clock fell too soon after frame sync");
  AST_SCLK_IDLE: assert property (sync_n |-> sclk)
    else $error("serial clock not idle high outside a frame");
  AST_LOW_PHASE: assert property ($fell(sclk) |-> s_low4)
    else $error("serial clock low phase wrong length");
  AST_HIGH_PHASE: assert property ($rose(sclk) && !sync_n |-> s_high4)
    else $error("serial clock high phase wrong length");
  AST_DIN_HOLD: assert property (!sclk |-> $stable(din))
    else $error("data moved while serial clock low");
  AST_FRAME_LEN: assert property ($rose(sync_n) |-> fall_cnt == 6'h20)
    else $error("frame ended without exactly 32 falls");
  AST_STROBE_PULSE: assert property ($fell(load_strobe_n) |-> s_strobe3)
    else $error("load strobe pulse wrong width");
  AST_CLEAR_PULSE: assert property ($fell(clear_n) |-> s_clear2)
    else $error("clear pulse wrong width");
  AST_EXCLUSIVE: assert property (!load_strobe_n |-> clear_n && sync_n)
    else $error("load strobe overlaps clear or frame");
endmodule : qdac_link_assertions
`default_nettype wire

// ---- bench/quad_dac_serial_load_clear_tb.sv ----
// testbench: host and converter joined by the link, plus a hand-driven fault link
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_load_clear_tb
  import qdac_pkg::*;
;
  typedef struct {bit sel; logic [131:0] v;} qdac_note_s;
  logic             clk_sys, rst, send, load_req, clear_req, ready;
  logic             done_p, abort_p, done1, abort2, done_p2, abort_p1, done2, abort1;
  logic [31:0]      frame, r;
  logic [3:0][15:0] dac1, in1, dac2, in2, m_dac, m_in;
  logic [1:0]       sel1, sel2, m_sel;
  logic [131:0]     got;
  int               failures, num_checks, seed;
  qdac_note_s       notes[$];
  qdac_note_s       nt;
  qdac_link_if      lnk();
  qdac_link_if      lnk2();

  //////////////////////////////////////////////////////////////////////////////
  qdac_host u_qdac_host (.clk_sys(clk_sys), .rst(rst), .send(send), .frame(frame),
    .load_req(load_req), .clear_req(clear_req), .ready(ready), .link(lnk.host));
  qdac_dev u_qdac_dev (.clk_sys(clk_sys), .rst(rst), .link(lnk.dev), .por_mid(1'b1),
    .dac_code(dac1), .input_code(in1), .clear_sel(sel1), .frame_done(done_p),
    .frame_abort(abort_p1));
  // second converter on a link driven by hand, so rule breaks can be made
  qdac_dev u_qdac_dev_flt (.clk_sys(clk_sys), .rst(rst), .link(lnk2.dev), .por_mid(1'b0),
    .dac_code(dac2), .input_code(in2), .clear_sel(sel2), .frame_done(done_p2),
    .frame_abort(abort_p));
  qdac_link_assertions u_qdac_link_assertions (.clk_sys(clk_sys), .rst(rst), .sclk(lnk.sclk),
    .sync_n(lnk.sync_n), .din(lnk.din), .load_strobe_n(lnk.load_strobe_n),
    .clear_n(lnk.clear_n));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // pulses are made sticky so a compare long after them still sees them
  always @(posedge clk_sys) begin
    if (done_p === 1'b1) done1 <= 1'b1;
    if (abort_p === 1'b1) abort2 <= 1'b1;
    if (abort_p1 === 1'b1) abort1 <= 1'b1;
    if (done_p2 === 1'b1) done2 <= 1'b1;
  end

  // watcher: pops the oldest expectation and compares the chosen converter
  always @(negedge clk_sys) begin
    if (notes.size() > 0) begin
      nt = notes.pop_front();
      got = nt.sel ? {done2, abort2, sel2, dac2, in2} : {done1, abort1, sel1, dac1, in1};
      num_checks++;
      if (got !== nt.v) begin
        failures++;
        $display("mismatch at %0t got %h exp %h", $time, got, nt.v);
      end
      if (nt.sel) begin
        {done2, abort2} = 2'b00;
      end else begin
        {done1, abort1} = 2'b00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] fr(input logic [3:0] c, input logic [3:0] a,
                                     input logic [15:0] d);
    return {4'h0, c, a, d, 4'h0};
  endfunction : fr

  // f holds the expected {done, abort} flags of the chosen converter
  task automatic note(input bit s, input logic [1:0] f);
    qdac_note_s n;
    n.sel = s;
    n.v = {f, m_sel, m_dac, m_in};
    notes.push_back(n);
  endtask : note

  task automatic report(input string name);
    repeat (4) @(posedge clk_sys);
    $display("test %s done", name);
  endtask : report

  // one host request; waits bounded for ready, then lets the converter settle
  task automatic hreq(input logic s, input logic l, input logic c, input logic [31:0] f);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    send <= s;
    load_req <= l;
    clear_req <= c;
    frame <= f;
    @(posedge clk_sys);
    send <= 1'b0;
    load_req <= 1'b0;
    clear_req <= 1'b0;
    @(posedge clk_sys);
    n = 0;
    while (ready !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 3000) failures++;
    repeat (8) @(posedge clk_sys);
    note(1'b0, {s, 1'b0});
  endtask : hreq

  // hand-made frame on the fault link, 125 ns serial clock, n bits then sync rise
  task automatic frame2(input logic [31:0] f, input int n);
    lnk2.sync_n = 1'b0;
    #62.5;
    for (int i = 0; i < n; i++) begin
      lnk2.din = f[31-i];
      #31 lnk2.sclk = 1'b0;
      #62.5 lnk2.sclk = 1'b1;
      #31.5;
    end
    lnk2.sync_n = 1'b1;
    lnk2.din = ~lnk2.din;
    #2000;
  endtask : frame2

  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  //////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs about 15k cycles, under a third of this span
  initial begin
    #400000;
    failures++;
    finish_test();
  end

  initial begin
    seed = 87531;
    {rst, send, load_req, clear_req, frame, failures, num_checks} = '0;
    {done1, abort2, done2, abort1} = 4'h0;
    rst = 1'b1;
    {lnk2.sclk, lnk2.sync_n, lnk2.din, lnk2.load_strobe_n, lnk2.clear_n} = 5'h1B;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    {m_dac, m_in, m_sel} = '0;
    note(1'b1, 2'b00);
    m_dac = {4{CODE_MID}};
    m_in = m_dac;
    m_sel = CLRSEL_ZERO;
    note(1'b0, 2'b00);
    report("power-on");
    // two channels loaded, then one strobe moves both together
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      m_in[k] = r[15:0];
      hreq(1'b1, 1'b0, 1'b0, fr(CMD_WR_IN, 4'(k), r[15:0]));
      m_in[k^1] = r[31:16];
      hreq(1'b1, 1'b0, 1'b0, fr(CMD_WR_IN, 4'(k^1), r[31:16]));
      m_dac = m_in;
      hreq(1'b0, 1'b1, 1'b0, '0);
    end
    report("strobe");
    r = $random(seed);
    m_in[0] = r[15:0];
    hreq(1'b1, 1'b0, 1'b0, fr(CMD_WR_IN, 4'h0, r[15:0]));
    m_dac[0] = m_in[0];
    hreq(1'b1, 1'b0, 1'b0, fr(CMD_UPDATE, 4'h0, 16'h0000));
    m_in[2] = r[31:16];
    m_dac[2] = r[31:16];
    hreq(1'b1, 1'b0, 1'b0, fr(CMD_WR_UPDATE, 4'h2, r[31:16]));
    m_in[1] = CODE_FULL;
    m_dac = m_in;
    hreq(1'b1, 1'b0, 1'b0, fr(CMD_WR_UPD_ALL, 4'h1, CODE_FULL));
    report("commands");
    // every clear select, each followed by a clear pulse
    for (int s = 2; s >= 0; s--) begin
      m_sel = s[1:0];
      hreq(1'b1, 1'b0, 1'b0, fr(CMD_SET_CLRCODE, 4'h0, {14'h0000, s[1:0]}));
      m_in = {4{(s == 2) ? CODE_FULL : (s == 1) ? CODE_MID : CODE_ZERO}};
      m_dac = m_in;
      hreq(1'b0, 1'b0, 1'b1, '0);
    end
    report("clear");
    // fault link: aborted frame, strobe under clear, strobe held low
    {m_dac, m_in, m_sel} = '0;
    r = $random(seed);
    frame2(fr(CMD_WR_IN, 4'h1, r[15:0]), 20);
    note(1'b1, 2'b01);
    @(posedge clk_sys);
    lnk2.clear_n <= 1'b0;
    frame2(fr(CMD_WR_IN, 4'h0, r[31:16]), 32);
    m_in[0] = r[31:16];
    note(1'b1, 2'b10);
    @(posedge clk_sys);
    lnk2.load_strobe_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    lnk2.load_strobe_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    note(1'b1, 2'b00);
    lnk2.clear_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    lnk2.load_strobe_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    m_dac[0] = r[31:16];
    note(1'b1, 2'b00);
    frame2(fr(CMD_WR_IN, 4'h3, r[15:0]), 32);
    m_in[3] = r[15:0];
    m_dac[3] = r[15:0];
    note(1'b1, 2'b10);
    report("fault link");
    repeat (20) @(posedge clk_sys);
    finish_test();
  end
endmodule : quad_dac_serial_load_clear_tb
`default_nettype wire
